// ### drph_core.sv
// drph_core: reset response of one drive on a shared two-drive cable.
// assumes all inputs are synchronous to clk; the cable pins are open drain
// and resolved outside; reset_n is the drive's own power-on reset.
//
// Function
// [R01] power-on, RESET- and software reset all start the response sequence
// [R02] host holds RESET- asserted at least 25 us
// [R03] BSY is set within 400 ns of RESET- negation
// [R04] DASP- and PDIAG- are released within 1 ms of RESET- negation
// [R05] a slave asserts DASP- within 400 ms after RESET- negation
// [R06] the slave keeps DASP- asserted at most 31 s
// [R07] master samples DASP- up to 450 ms; assertion means slave present
// [R08] no DASP- within 450 ms: master records no slave attached
// [R09] after detection master watches PDIAG- for slave self-test result
// [R10] hardware reset repeats presence sampling, then PDIAG- check
// [R11] slave DASP- ends at first host command, 31 s, or software reset; here a software reset restarts the test phase with DASP- pulled
// [R12] power-on: PDIAG- negated, asserted by 30 s, negated by 31 s
// [R13] software reset: master skips DASP-, watches PDIAG- up to 31 s
// [R14] software reset: slave PDIAG- negated, asserted by 30 s, off by 31 s
// [R15] slave drives DASP- as the inverse of its PDIAG-; here DASP- is pulled only in the test phase and both are released in idle
// [R16] diagnostic command: master ignores DASP-, watches PDIAG- up to 6 s
// [R17] diagnostic command: slave PDIAG- asserted by 5 s, negated by 6 s
// [R18] PDIAG- not seen before the window ends: slave diagnostic failed
module drph_core
  import drph_pkg::*;
#(
  parameter int unsigned P_SETTLE_CYC = SETTLE_CYC,
  parameter int unsigned P_PRES_CYC = PRES_CYC,
  parameter int unsigned P_PWR_TEST_CYC = PWR_TEST_CYC,
  parameter int unsigned P_PWR_RPT_CYC = PWR_RPT_CYC,
  parameter int unsigned P_DASP_MAX_CYC = DASP_MAX_CYC,
  parameter int unsigned P_SW_MON_CYC = SW_MON_CYC,
  parameter int unsigned P_DIAG_TEST_CYC = DIAG_TEST_CYC,
  parameter int unsigned P_DIAG_RPT_CYC = DIAG_RPT_CYC,
  parameter int unsigned P_DIAG_MON_CYC = DIAG_MON_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hw_reset_n,
  input wire logic sw_reset,
  input wire logic diag_cmd,
  input wire logic host_cmd,
  input wire logic cfg_slave,
  input wire logic selftest_done,
  input wire logic selftest_pass,
  input wire logic dasp_in_n,
  input wire logic pdiag_in_n,
  output drph_od_t dasp_drv,
  output drph_od_t pdiag_drv,
  output drph_stat_t status
);

  typedef enum logic [2:0] {
    M_IDLE,
    M_PRES,
    M_SETTLE,
    M_MON
  } drph_mst_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_TEST,
    S_RPT
  } drph_slv_t;

  localparam logic [CNT_W-1:0] SETTLE_LIM = CNT_W'(P_SETTLE_CYC);
  localparam logic [CNT_W-1:0] PRES_LIM = CNT_W'(P_PRES_CYC);
  localparam logic [CNT_W-1:0] DASP_LIM = CNT_W'(P_DASP_MAX_CYC);

  // event detection
  logic por_q;
  logic hw_prev_q;
  logic hw_rise;
  logic hw_held;
  logic ev_valid;
  drph_ev_t ev_kind;

  // role and sequence state
  logic role_slave_q;
  drph_mst_t mst_q;
  drph_slv_t slv_q;
  logic [CNT_W-1:0] mon_lim_q;
  logic [CNT_W-1:0] test_lim_q;
  logic [CNT_W-1:0] rpt_lim_q;
  logic cmd_seen_q;
  logic present_q;
  logic pass_q;
  logic fail_q;
  logic bsy_q;

  // pin drive flops
  logic dasp_oe_n_q;
  logic pdiag_oe_n_q;
  logic pin_lvl_q;

  // timers
  logic mst_clr;
  logic slv_clr;
  logic [CNT_W-1:0] mst_cnt;
  logic [CNT_W-1:0] slv_cnt;

  drph_timer u_mst_tmr (
    .clk(clk),
    .reset_n(reset_n),
    .clear(mst_clr),
    .count(mst_cnt)
  );

  drph_timer u_slv_tmr (
    .clk(clk),
    .reset_n(reset_n),
    .clear(slv_clr),
    .count(slv_cnt)
  );

  // first cycle after the drive's own reset counts as the power-on event
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      por_q <= 1'b1;
    end else begin
      por_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hw_prev_q <= 1'b1;
    end else begin
      hw_prev_q <= hw_reset_n;
    end
  end

  assign hw_rise = hw_reset_n & ~hw_prev_q;
  assign hw_held = ~hw_reset_n;

  // while RESET- is held nothing else may start a sequence
  always_comb begin
    ev_valid = 1'b0;
    ev_kind = DRPH_EV_POR;
    if (por_q) begin
      ev_valid = 1'b1; // see [R01]
      ev_kind = DRPH_EV_POR;
    end else if (hw_rise) begin
      ev_valid = 1'b1; // see [R01]
      ev_kind = DRPH_EV_HW;
    end else if (!hw_held && sw_reset) begin
      ev_valid = 1'b1; // see [R01]
      ev_kind = DRPH_EV_SW;
    end else if (!hw_held && diag_cmd) begin
      ev_valid = 1'b1;
      ev_kind = DRPH_EV_DIAG;
    end
  end

  // strap is caught at the power-on or hardware reset event, not in reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      role_slave_q <= 1'b0;
    end else if (ev_valid &&
                 (ev_kind == DRPH_EV_POR || ev_kind == DRPH_EV_HW)) begin
      role_slave_q <= cfg_slave;
    end
  end

  // the role used in the event cycle must be the freshly strapped one
  logic slave_now;
  assign slave_now = (ev_valid &&
                      (ev_kind == DRPH_EV_POR || ev_kind == DRPH_EV_HW)) ?
                     cfg_slave : role_slave_q;

  // master side: presence window, settle, PDIAG- monitor
  always_ff @(posedge clk) begin
    if (!reset_n || hw_held) begin
      mst_q <= M_IDLE;
    end else if (ev_valid && !slave_now) begin
      unique case (ev_kind)
        DRPH_EV_POR, DRPH_EV_HW: begin
          mst_q <= M_PRES; // see [R07] [R10]
        end
        DRPH_EV_SW, DRPH_EV_DIAG: begin
          // no DASP- sampling here, only PDIAG- when a slave is known
          mst_q <= present_q ? M_SETTLE : M_IDLE; // see [R13] [R16]
        end
      endcase
    end else begin
      unique case (mst_q)
        M_IDLE: begin
          mst_q <= M_IDLE;
        end
        M_PRES: begin
          if (!dasp_in_n) begin
            mst_q <= M_MON; // see [R09]
          end else if (mst_cnt >= PRES_LIM - 1'b1) begin
            mst_q <= M_IDLE; // see [R08]
          end
        end
        M_SETTLE: begin
          // give the slave time to drop a stale PDIAG- before watching it
          if (mst_cnt >= SETTLE_LIM - 1'b1) begin
            mst_q <= M_MON;
          end
        end
        M_MON: begin
          if (!pdiag_in_n || mst_cnt >= mon_lim_q - 1'b1) begin
            mst_q <= M_IDLE;
          end
        end
        default: begin
          mst_q <= M_IDLE;
        end
      endcase
    end
  end

  assign mst_clr = (ev_valid && !slave_now) ||
                   (mst_q == M_PRES && !dasp_in_n) ||
                   (mst_q == M_SETTLE && mst_cnt >= SETTLE_LIM - 1'b1);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mon_lim_q <= CNT_W'(P_PWR_RPT_CYC);
    end else if (ev_valid && !slave_now) begin
      unique case (ev_kind)
        DRPH_EV_POR, DRPH_EV_HW: mon_lim_q <= CNT_W'(P_PWR_RPT_CYC);
        DRPH_EV_SW: mon_lim_q <= CNT_W'(P_SW_MON_CYC); // see [R13]
        DRPH_EV_DIAG: mon_lim_q <= CNT_W'(P_DIAG_MON_CYC); // see [R16]
      endcase
    end
  end

  // presence is only learned anew at power-on or hardware reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      present_q <= 1'b0;
    end else if (ev_valid && !slave_now &&
                 (ev_kind == DRPH_EV_POR || ev_kind == DRPH_EV_HW)) begin
      present_q <= 1'b0;
    end else if (mst_q == M_PRES && !dasp_in_n) begin
      present_q <= 1'b1; // see [R07]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || hw_held) begin
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (ev_valid && !slave_now) begin
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end else if (mst_q == M_MON) begin
      if (!pdiag_in_n) begin
        pass_q <= 1'b1; // see [R09]
      end else if (mst_cnt >= mon_lim_q - 1'b1) begin
        fail_q <= 1'b1; // see [R18]
      end
    end
  end

  // slave side: self-test phase with DASP-, then PDIAG- report phase
  always_ff @(posedge clk) begin
    if (!reset_n || hw_held) begin
      slv_q <= S_IDLE;
    end else if (ev_valid && slave_now) begin
      slv_q <= S_TEST; // see [R12] [R14] [R17]
    end else begin
      unique case (slv_q)
        S_IDLE: begin
          slv_q <= S_IDLE;
        end
        S_TEST: begin
          if (slv_cnt >= test_lim_q) begin
            // a late or failing test never asserts PDIAG-
            slv_q <= S_IDLE;
          end else if (selftest_done && selftest_pass) begin
            slv_q <= S_RPT;
          end else if (selftest_done) begin
            slv_q <= S_IDLE;
          end
        end
        S_RPT: begin
          if (slv_cnt >= rpt_lim_q - 1'b1) begin
            slv_q <= S_IDLE; // see [R12] [R14] [R17]
          end
        end
        default: begin
          slv_q <= S_IDLE;
        end
      endcase
    end
  end

  assign slv_clr = ev_valid && slave_now;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      test_lim_q <= CNT_W'(P_PWR_TEST_CYC);
      rpt_lim_q <= CNT_W'(P_PWR_RPT_CYC);
    end else if (ev_valid && slave_now) begin
      if (ev_kind == DRPH_EV_DIAG) begin
        test_lim_q <= CNT_W'(P_DIAG_TEST_CYC); // see [R17]
        rpt_lim_q <= CNT_W'(P_DIAG_RPT_CYC);
      end else begin
        test_lim_q <= CNT_W'(P_PWR_TEST_CYC); // see [R12] [R14]
        rpt_lim_q <= CNT_W'(P_PWR_RPT_CYC);
      end
    end
  end

  // a host command ends DASP- early; the new sequence forgets old commands
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmd_seen_q <= 1'b0;
    end else if (ev_valid) begin
      cmd_seen_q <= 1'b0;
    end else if (host_cmd) begin
      cmd_seen_q <= 1'b1; // see [R11]
    end
  end

  // BSY rises while RESET- is held, so it is already set at negation
  always_ff @(posedge clk) begin
    if (!reset_n || hw_held) begin
      bsy_q <= RST_BSY; // see [R03]
    end else if (ev_valid) begin
      bsy_q <= 1'b1;
    end else if (role_slave_q) begin
      bsy_q <= (slv_q == S_TEST);
    end else begin
      bsy_q <= (mst_q != M_IDLE);
    end
  end

  // DASP- pulled while PDIAG- is negated in the test phase
  always_ff @(posedge clk) begin
    if (!reset_n || hw_held) begin
      dasp_oe_n_q <= RST_OE_N; // see [R04]
    end else if (role_slave_q && slv_q == S_TEST && !cmd_seen_q &&
                 slv_cnt < DASP_LIM - 1'b1) begin
      dasp_oe_n_q <= 1'b0; // see [R05] [R06] [R11] [R15]
    end else begin
      dasp_oe_n_q <= 1'b1;
    end
  end

  // PDIAG- pulled only during the report phase
  always_ff @(posedge clk) begin
    if (!reset_n || hw_held) begin
      pdiag_oe_n_q <= RST_OE_N; // see [R04]
    end else begin
      pdiag_oe_n_q <= ~(role_slave_q && slv_q == S_RPT); // see [R15]
    end
  end

  // open-drain pins only ever pull low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_lvl_q <= 1'b0;
    end else begin
      pin_lvl_q <= 1'b0;
    end
  end

  assign dasp_drv.out = pin_lvl_q;
  assign dasp_drv.oe_n = dasp_oe_n_q;
  assign pdiag_drv.out = pin_lvl_q;
  assign pdiag_drv.oe_n = pdiag_oe_n_q;

  assign status.bsy = bsy_q;
  assign status.role_slave = role_slave_q;
  assign status.slave_present = present_q;
  assign status.slave_diag_pass = pass_q;
  assign status.slave_diag_fail = fail_q;

endmodule

// ### drph_pkg.sv
// drph_pkg: shared types and timing for the drive reset/presence handshake.
// assumes a single 10 MHz clock; all counts are cycles of that clock.
package drph_pkg;

  // clock rate, used to turn printed times into cycle counts
  localparam int unsigned CLK_KHZ = 10_000;

  // printed times, in their own units
  localparam int unsigned T_SETTLE_MS = 1;
  localparam int unsigned T_PRES_MS = 450;
  localparam int unsigned T_PWR_TEST_S = 30;
  localparam int unsigned T_PWR_RPT_S = 31;
  localparam int unsigned T_DASP_MAX_S = 31;
  localparam int unsigned T_SW_MON_S = 31;
  localparam int unsigned T_DIAG_TEST_S = 5;
  localparam int unsigned T_DIAG_RPT_S = 6;
  localparam int unsigned T_DIAG_MON_S = 6;

  // least times round up, longest times round down; all are exact here
  localparam int unsigned SETTLE_CYC = T_SETTLE_MS * CLK_KHZ;
  localparam int unsigned PRES_CYC = T_PRES_MS * CLK_KHZ;
  localparam int unsigned PWR_TEST_CYC = T_PWR_TEST_S * 1000 * CLK_KHZ;
  localparam int unsigned PWR_RPT_CYC = T_PWR_RPT_S * 1000 * CLK_KHZ;
  localparam int unsigned DASP_MAX_CYC = T_DASP_MAX_S * 1000 * CLK_KHZ;
  localparam int unsigned SW_MON_CYC = T_SW_MON_S * 1000 * CLK_KHZ;
  localparam int unsigned DIAG_TEST_CYC = T_DIAG_TEST_S * 1000 * CLK_KHZ;
  localparam int unsigned DIAG_RPT_CYC = T_DIAG_RPT_S * 1000 * CLK_KHZ;
  localparam int unsigned DIAG_MON_CYC = T_DIAG_MON_S * 1000 * CLK_KHZ;

  localparam int unsigned CNT_W = 32;

  // reset values of the BSY status output and of the pin output enables
  localparam logic RST_BSY = 1'b1;
  localparam logic RST_OE_N = 1'b1;

  typedef enum logic [1:0] {
    DRPH_EV_POR,
    DRPH_EV_HW,
    DRPH_EV_SW,
    DRPH_EV_DIAG
  } drph_ev_t;

  // open-drain pin drive: oe_n low means the line is pulled low
  typedef struct packed {
    logic out;
    logic oe_n;
  } drph_od_t;

  typedef struct packed {
    logic bsy;
    logic role_slave;
    logic slave_present;
    logic slave_diag_pass;
    logic slave_diag_fail;
  } drph_stat_t;

endpackage

// ### drph_timer.sv
// drph_timer: saturating elapsed-cycle counter, restarted by a clear pulse.
// assumes clear is a one-cycle pulse in the clk domain.
module drph_timer
  import drph_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  output logic [CNT_W-1:0] count
);

  logic [CNT_W-1:0] count_q;

  // saturate rather than wrap so a stuck sequence never looks fresh again
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (count_q != {CNT_W{1'b1}}) begin
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign count = count_q;

endmodule

// ### drph_core_props.sv
// drph_core_props: port-level checks of the reset handshake.
// assumes it is bound to drph_core and sees its ports only.
module drph_core_props
  import drph_pkg::*;
#(
  parameter int unsigned P_PRES_CYC = PRES_CYC,
  parameter int unsigned P_DASP_MAX_CYC = DASP_MAX_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hw_reset_n,
  input wire logic sw_reset,
  input wire logic diag_cmd,
  input wire logic host_cmd,
  input wire logic cfg_slave,
  input wire logic selftest_done,
  input wire logic pdiag_in_n,
  input wire drph_od_t dasp_drv,
  input wire drph_od_t pdiag_drv,
  input wire drph_stat_t status
);
  int unsigned dasp_cnt_q;
  int unsigned pres_cnt_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // counters, since the real windows far exceed any delay range
  always_ff @(posedge clk) begin
    if (!reset_n || dasp_drv.oe_n || !status.role_slave) begin
      dasp_cnt_q <= 0;
    end else begin
      dasp_cnt_q <= dasp_cnt_q + 1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n || !hw_reset_n || !status.bsy || status.slave_present ||
        status.role_slave) begin
      pres_cnt_q <= 0;
    end else begin
      pres_cnt_q <= pres_cnt_q + 1;
    end
  end
  sequence hw_rel_s;
    !hw_reset_n ##1 hw_reset_n;
  endsequence
  sequence host_seen_s;
    status.role_slave && host_cmd && hw_reset_n && !sw_reset && !diag_cmd
      ##1 hw_reset_n && !sw_reset && !diag_cmd;
  endsequence
  bsy_hw_hold_a: assert property (!hw_reset_n |=> status.bsy)
    else $error("bsy low during drive reset");
  lines_hw_free_a: assert property (
    !hw_reset_n |=> dasp_drv.oe_n && pdiag_drv.oe_n)
    else $error("cable line pulled during drive reset");
  bsy_event_a: assert property (
    (sw_reset || diag_cmd) && hw_reset_n |=> status.bsy)
    else $error("bsy not set after reset event");
  slave_excl_a: assert property (
    status.role_slave |-> dasp_drv.oe_n || pdiag_drv.oe_n)
    else $error("slave pulls both lines");
  dasp_limit_a: assert property (dasp_cnt_q < P_DASP_MAX_CYC)
    else $error("slave held dasp too long");
  pres_window_a: assert property (pres_cnt_q <= P_PRES_CYC + 4)
    else $error("presence window overran");
  host_drop_a: assert property (host_seen_s |=> dasp_drv.oe_n)
    else $error("dasp kept after host command");
  pass_cause_a: assert property (
    $rose(status.slave_diag_pass) |-> !$past(pdiag_in_n))
    else $error("pass without pdiag seen");
  fail_cause_a: assert property (
    $rose(status.slave_diag_fail) |-> $past(pdiag_in_n))
    else $error("fail while pdiag asserted");
  slave_dasp_on_a: assert property (
    hw_rel_s ##0 (cfg_slave && !host_cmd && !selftest_done)
      ##1 (hw_reset_n && !host_cmd && !selftest_done) |=> !dasp_drv.oe_n)
    else $error("slave dasp late after reset");
endmodule

bind drph_core drph_core_props #(
  .P_PRES_CYC(P_PRES_CYC),
  .P_DASP_MAX_CYC(P_DASP_MAX_CYC)
) u_props (
  .clk(clk),
  .reset_n(reset_n),
  .hw_reset_n(hw_reset_n),
  .sw_reset(sw_reset),
  .diag_cmd(diag_cmd),
  .host_cmd(host_cmd),
  .cfg_slave(cfg_slave),
  .selftest_done(selftest_done),
  .pdiag_in_n(pdiag_in_n),
  .dasp_drv(dasp_drv),
  .pdiag_drv(pdiag_drv),
  .status(status)
);

// ### drph_peer_model.sv
// drph_peer_model: behavioural slave drive on the shared cable.
// assumes open-drain lines with pull-ups resolved by the bench.
module drph_peer_model (
  input wire logic clk,
  input wire logic go,
  input wire logic on,
  input wire logic pass,
  input wire logic slow,
  output logic dasp_oe_n,
  output logic pdiag_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int t_q = 1000;
  always_ff @(posedge clk) begin
    if (go) begin
      t_q <= 0;
    end else if (t_q < 1000) begin
      t_q <= t_q + 1;
    end
  end
  // slow dasp lands past the master window on purpose
  assign pdiag_oe_n = !(on && pass && t_q >= (slow ? 40 : 15) &&
                        t_q < (slow ? 50 : 25));
  assign dasp_oe_n = !(on && pdiag_oe_n && t_q >= (slow ? 30 : 5) &&
                       t_q < 200);
endmodule

// ### tb.sv
// tb: self-checking bench for drph_core beside a peer drive model.
// assumes drph_pkg, drph_core and drph_peer_model are compiled first.
module tb
  import drph_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SETTLE = 4;
  localparam int PRES = 20;
  localparam int PRPT = 60;
  localparam int DRPT = 45;
  localparam int SWMON = 60;
  localparam int DMON = 50;
  logic clk, reset_n, hw_reset_n, sw_reset, diag_cmd, host_cmd;
  logic cfg_slave, st_done, st_pass, p_go, p_on, p_pass, p_slow;
  logic p_dasp_oe_n, p_pdiag_oe_n;
  drph_od_t dasp_drv, pdiag_drv;
  drph_stat_t status;
  int errors, checked;
  wire dasp_in_n = dasp_drv.oe_n & p_dasp_oe_n;
  wire pdiag_in_n = pdiag_drv.oe_n & p_pdiag_oe_n;
  drph_core #(.P_SETTLE_CYC(SETTLE), .P_PRES_CYC(PRES),
    .P_PWR_TEST_CYC(40), .P_PWR_RPT_CYC(PRPT), .P_DASP_MAX_CYC(60),
    .P_SW_MON_CYC(SWMON), .P_DIAG_TEST_CYC(30), .P_DIAG_RPT_CYC(DRPT),
    .P_DIAG_MON_CYC(DMON)) u_dut (
    .clk(clk),
    .reset_n(reset_n),
    .hw_reset_n(hw_reset_n),
    .sw_reset(sw_reset),
    .diag_cmd(diag_cmd),
    .host_cmd(host_cmd),
    .cfg_slave(cfg_slave),
    .selftest_done(st_done),
    .selftest_pass(st_pass),
    .dasp_in_n(dasp_in_n),
    .pdiag_in_n(pdiag_in_n),
    .dasp_drv(dasp_drv),
    .pdiag_drv(pdiag_drv),
    .status(status)
  );
  drph_peer_model u_peer (
    .clk(clk),
    .go(p_go),
    .on(p_on),
    .pass(p_pass),
    .slow(p_slow),
    .dasp_oe_n(p_dasp_oe_n),
    .pdiag_oe_n(p_pdiag_oe_n)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic pick(int k);
    case (k)
      0: return status.bsy;
      1: return status.slave_present;
      2: return status.slave_diag_pass;
      3: return status.slave_diag_fail;
      4: return dasp_drv.oe_n;
      default: return pdiag_drv.oe_n;
    endcase
  endfunction
  task automatic end_of_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(string name, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic wait_sig(string name, int k, logic v, int lim);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (pick(k) !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(name, v, pick(k));
    if (pick(k) !== v) end_of_test();
  endtask
  task automatic pulse(int k);
    @(posedge clk);
    case (k)
      0: sw_reset <= 1'b1;
      1: diag_cmd <= 1'b1;
      2: host_cmd <= 1'b1;
      default: st_done <= 1'b1;
    endcase
    p_go <= (k < 2);
    @(posedge clk);
    {sw_reset, diag_cmd, host_cmd, st_done, p_go} <= '0;
  endtask
  task automatic hw_pulse();
    @(posedge clk);
    hw_reset_n <= 1'b0;
    repeat (250) @(posedge clk);
    hw_reset_n <= 1'b1;
    p_go <= 1'b1;
    @(posedge clk);
    p_go <= 1'b0;
  endtask
  task automatic t_por_master();
    wait_sig("present", 1, 1'b1, PRES);
    wait_sig("pass", 2, 1'b1, PRPT);
    wait_sig("bsy", 0, 1'b0, 4);
  endtask
  // late slave: bsy stands for the whole presence window, then drops
  task automatic t_hw_late();
    @(posedge clk);
    p_slow <= 1'b1;
    hw_pulse();
    wait_sig("bsy", 0, 1'b1, 0);
    repeat (PRES - 4) @(posedge clk);
    #1;
    check("bsy", 1'b1, status.bsy);
    wait_sig("bsy", 0, 1'b0, 8);
    check("present", 1'b0, status.slave_present);
  endtask
  task automatic t_sw_refused();
    pulse(0);
    repeat (SETTLE + SWMON + 4) @(posedge clk);
    #1;
    check("pass", 1'b0, status.slave_diag_pass);
    check("fail", 1'b0, status.slave_diag_fail);
  endtask
  task automatic t_hw_fail();
    @(posedge clk);
    {p_slow, p_pass} <= 2'b00;
    hw_pulse();
    wait_sig("present", 1, 1'b1, PRES);
    repeat (PRPT - 8) @(posedge clk);
    #1;
    check("fail", 1'b0, status.slave_diag_fail);
    wait_sig("fail", 3, 1'b1, 12);
  endtask
  task automatic t_diag_fail();
    pulse(1);
    wait_sig("fail", 3, 1'b1, SETTLE + DMON + 4);
    check("pass", 1'b0, status.slave_diag_pass);
  endtask
  task automatic t_sw_pass();
    @(posedge clk);
    {p_slow, p_pass} <= 2'b11;
    pulse(0);
    wait_sig("fail", 3, 1'b0, 2);
    wait_sig("pass", 2, 1'b1, SETTLE + SWMON);
  endtask
  task automatic t_slave_hw();
    @(posedge clk);
    {cfg_slave, p_on} <= 2'b10;
    hw_pulse();
    wait_sig("dasp", 4, 1'b0, 3);
    check("role", 1'b1, status.role_slave);
    check("dasp out", 1'b0, dasp_drv.out);
    pulse(3);
    wait_sig("pdiag", 5, 1'b0, 3);
    check("dasp", 1'b1, dasp_drv.oe_n);
    check("pdiag out", 1'b0, pdiag_drv.out);
    check("bsy", 1'b0, status.bsy);
    wait_sig("pdiag", 5, 1'b1, PRPT);
  endtask
  task automatic t_slave_diag();
    pulse(1);
    wait_sig("dasp", 4, 1'b0, 3);
    pulse(2);
    wait_sig("dasp", 4, 1'b1, 3);
    pulse(3);
    wait_sig("pdiag", 5, 1'b0, 3);
    wait_sig("pdiag", 5, 1'b1, DRPT);
  endtask
  // second software reset ends in a failed self-test: PDIAG- stays off
  task automatic t_slave_sw();
    pulse(0);
    wait_sig("dasp", 4, 1'b0, 3);
    wait_sig("dasp", 4, 1'b1, 42);
    check("pdiag", 1'b1, pdiag_drv.oe_n);
    pulse(0);
    st_pass <= 1'b0;
    pulse(3);
    wait_sig("dasp", 4, 1'b1, 3);
    repeat (3) @(posedge clk);
    #1;
    check("pdiag", 1'b1, pdiag_drv.oe_n);
    check("bsy", 1'b0, status.bsy);
  endtask
  initial begin
    {reset_n, sw_reset, diag_cmd, host_cmd, cfg_slave, st_done} = '0;
    {hw_reset_n, st_pass, p_on, p_pass} = '1;
    {p_go, p_slow} = '0;
    errors = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    p_go <= 1'b1;
    @(posedge clk);
    p_go <= 1'b0;
    t_por_master();
    t_hw_late();
    t_sw_refused();
    t_hw_fail();
    t_diag_fail();
    t_sw_pass();
    t_slave_hw();
    t_slave_diag();
    t_slave_sw();
    end_of_test();
  end
endmodule
